// ---- src/ieru_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ieru_consts.vh"

module ieru_top #(
   parameter NPER = `IERU_NUM_PERIPH,
   parameter NEXT = `IERU_NUM_EXT,
   parameter AW   = `IERU_ADDR_W
) (
   input  wire                 ref_clk_i,
   input  wire                 rst_n_i,
   input  wire                 psel_i,
   input  wire                 penable_i,
   input  wire                 pwrite_i,
   input  wire [AW-1:0]        paddr_i,
   input  wire [31:0]          pwdata_i,
   output reg  [31:0]          prdata_o,
   output wire                 pready_o,
   output wire                 pslverr_o,
   input  wire [NPER-1:0]      periph_irq_i,
   input  wire [NEXT-1:0]      ext_irq_pin_i,
   input  wire [NEXT-1:0]      ext_irq_ack_i,
   input  wire                 nmi_pin_i,
   input  wire                 wdt_underflow_i,
   input  wire                 wdt_refresh_err_i,
   input  wire                 voltage_monitor_one_i,
   input  wire                 sram_parity_err_irq_i,
   input  wire                 sleep_mode_i,
   input  wire                 standby_mode_i,
   input  wire                 snooze_mode_i,
   output reg  [NPER+NEXT-1:0] nvc_irq_o,
   output reg  [NPER+NEXT-1:0] dtc_req_o,
   output reg                  nmi_o,
   output reg                  wake_o,
   output reg                  irq_o
);

   localparam NIRQ = NPER + NEXT;
   localparam NNMI = `IERU_NUM_NMI;
   localparam SL   = `IERU_ST_NMI_LSB;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function [31:0] word_of;
      input [NIRQ-1:0] v;
      input            hi;
      begin
         if (hi)
            word_of = {{(64-NIRQ){1'b0}}, v[NIRQ-1:32]};
         else
            word_of = v[31:0];
      end
   endfunction

   function [NIRQ-1:0] put_word;
      input [NIRQ-1:0] v;
      input            hi;
      input [31:0]     d;
      begin
         put_word = v;
         if (hi)
            put_word[NIRQ-1:32] = d[NIRQ-33:0];
         else
            put_word[31:0] = d;
      end
   endfunction

   // -----------------------------------------------------------
   // reset release
   // -----------------------------------------------------------
   reg rst_meta_r;
   reg rst_n_r;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   reg [NIRQ-1:0]   irq_en_r;
   reg [NIRQ-1:0]   dtc_sel_r;
   reg [NIRQ-1:0]   sby_end_r;
   reg [2*NEXT-1:0] ext_mode_r;
   reg              nmi_rise_r;
   reg [NNMI-1:0]   nmi_en_r;
   reg              nmi_lock_r;
   reg [NEXT-1:0]   ext_pend_r;
   reg [NNMI-1:0]   nmi_stat_r;
   reg [31:0]       mask_r;

   wire [NEXT:0]    pin_sync;
   wire [NEXT:0]    pin_edge;
   wire [NIRQ-1:0]  src;
   wire [31:0]      status;
   wire [NNMI-1:0]  nmi_ev;
   wire             wr_en;
   wire             rd_setup;
   reg              hit;
   reg  [31:0]      rdata_nxt;
   reg  [NEXT-1:0]  ext_pend_nxt;
   reg  [NNMI-1:0]  nmi_stat_nxt;

   // -----------------------------------------------------------
   // pin capture
   // -----------------------------------------------------------
   // synchronise pins first
   ieru_sync #(
      .W       (NEXT + 1)
   ) u_sync (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n_r),
      .d_i     ({nmi_pin_i, ext_irq_pin_i}),
      .q_o     (pin_sync)
   );

   ieru_edge_det #(
      .W       (NEXT + 1)
   ) u_edge (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n_r),
      .lvl_i   (pin_sync),
      .mode_i  ({1'b0, nmi_rise_r, ext_mode_r}),
      .edge_o  (pin_edge)
   );

   // -----------------------------------------------------------
   // sources and events
   // -----------------------------------------------------------
   // peripheral and pin sources
   assign src = {ext_pend_r, periph_irq_i};

   assign nmi_ev[`IERU_NMI_WDT]    = wdt_underflow_i | wdt_refresh_err_i;
   assign nmi_ev[`IERU_NMI_LVD1]   = voltage_monitor_one_i;
   assign nmi_ev[`IERU_NMI_PARITY] = sram_parity_err_irq_i;
   assign nmi_ev[`IERU_NMI_PIN]    = pin_edge[NEXT];

   assign status = {{(32-SL-NNMI){1'b0}}, nmi_stat_r,
                    {(SL-NEXT){1'b0}}, ext_pend_r};

   // -----------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   always @* begin
      hit       = 1'b1;
      rdata_nxt = `IERU_RST_WORD;
      case (paddr_i)
         `IERU_OFF_IRQ_EN0:  rdata_nxt = word_of(irq_en_r, 1'b0);
         `IERU_OFF_IRQ_EN1:  rdata_nxt = word_of(irq_en_r, 1'b1);
         `IERU_OFF_DTC_SEL0: rdata_nxt = word_of(dtc_sel_r, 1'b0);
         `IERU_OFF_DTC_SEL1: rdata_nxt = word_of(dtc_sel_r, 1'b1);
         `IERU_OFF_SBY_END0: rdata_nxt = word_of(sby_end_r, 1'b0);
         `IERU_OFF_SBY_END1: rdata_nxt = word_of(sby_end_r, 1'b1);
         `IERU_OFF_EXT_MODE: rdata_nxt = {{(32-2*NEXT){1'b0}}, ext_mode_r};
         `IERU_OFF_NMI_CFG:  rdata_nxt = {31'h0000_0000, nmi_rise_r};
         `IERU_OFF_NMI_EN:   rdata_nxt = {{(32-NNMI){1'b0}}, nmi_en_r};
         `IERU_OFF_STATUS:   rdata_nxt = status;
         `IERU_OFF_MASK:     rdata_nxt = mask_r;
         `IERU_OFF_SRC0:     rdata_nxt = word_of(src, 1'b0);
         `IERU_OFF_SRC1:     rdata_nxt = word_of(src, 1'b1);
         default:            hit = 1'b0;
      endcase
   end

   // read data captured in setup, so it stands through access
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r)
         prdata_o <= `IERU_RST_WORD;
      else if (rd_setup)
         prdata_o <= rdata_nxt;
   end

   // -----------------------------------------------------------
   // sticky flags: a new event wins over a clear
   // -----------------------------------------------------------
   always @* begin
      ext_pend_nxt = ext_pend_r & ~ext_irq_ack_i;
      nmi_stat_nxt = nmi_stat_r;
      if (wr_en && paddr_i == `IERU_OFF_STATUS) begin
         ext_pend_nxt = ext_pend_nxt & ~pwdata_i[NEXT-1:0];
         nmi_stat_nxt = nmi_stat_nxt & ~pwdata_i[SL+NNMI-1:SL];
      end
      ext_pend_nxt = ext_pend_nxt | pin_edge[NEXT-1:0];
      nmi_stat_nxt = nmi_stat_nxt | nmi_ev;
   end

   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_en_r   <= {NIRQ{1'b0}};
         dtc_sel_r  <= {NIRQ{1'b0}};
         sby_end_r  <= {NIRQ{1'b0}};
         ext_mode_r <= `IERU_RST_EXT_MODE;
         nmi_rise_r <= 1'b0;
         nmi_en_r   <= `IERU_RST_NMI_EN;
         nmi_lock_r <= 1'b0;
         mask_r     <= `IERU_RST_WORD;
         ext_pend_r <= {NEXT{1'b0}};
         nmi_stat_r <= {NNMI{1'b0}};
      end else begin
         ext_pend_r <= ext_pend_nxt;
         nmi_stat_r <= nmi_stat_nxt;
         if (wr_en) begin
            case (paddr_i)
               `IERU_OFF_IRQ_EN0:
                  irq_en_r <= put_word(irq_en_r, 1'b0, pwdata_i);
               `IERU_OFF_IRQ_EN1:
                  irq_en_r <= put_word(irq_en_r, 1'b1, pwdata_i);
               `IERU_OFF_DTC_SEL0:
                  dtc_sel_r <= put_word(dtc_sel_r, 1'b0, pwdata_i);
               `IERU_OFF_DTC_SEL1:
                  dtc_sel_r <= put_word(dtc_sel_r, 1'b1, pwdata_i);
               `IERU_OFF_SBY_END0:
                  sby_end_r <= put_word(sby_end_r, 1'b0, pwdata_i);
               `IERU_OFF_SBY_END1:
                  sby_end_r <= put_word(sby_end_r, 1'b1, pwdata_i);
               `IERU_OFF_EXT_MODE:
                  ext_mode_r <= pwdata_i[2*NEXT-1:0];
               `IERU_OFF_NMI_CFG:
                  if (!nmi_lock_r)
                     nmi_rise_r <= pwdata_i[`IERU_NMI_CFG_RISE];
               `IERU_OFF_NMI_EN:
                  if (!nmi_lock_r) begin
                     nmi_en_r   <= pwdata_i[NNMI-1:0];
                     nmi_lock_r <= 1'b1;
                  end
               `IERU_OFF_MASK:
                  mask_r <= pwdata_i;
               default: ;
            endcase
         end
      end
   end

   // -----------------------------------------------------------
   // routing and wake
   // -----------------------------------------------------------
   always @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         nvc_irq_o <= {NIRQ{1'b0}};
         dtc_req_o <= {NIRQ{1'b0}};
         nmi_o     <= 1'b0;
         wake_o    <= 1'b0;
         irq_o     <= 1'b0;
      end else begin
         nvc_irq_o <= src & irq_en_r & ~dtc_sel_r;
         dtc_req_o <= src & irq_en_r & dtc_sel_r;
         nmi_o     <= |(nmi_stat_r & nmi_en_r);
         irq_o     <= |(status & mask_r);
         wake_o    <= (|(nmi_stat_r & nmi_en_r)) |
                      (sleep_mode_i & (|src)) |
                      ((standby_mode_i | snooze_mode_i) & (|(src & sby_end_r)));
      end
   end

endmodule

`default_nettype wire

// ---- src/ieru_consts.vh ----
`ifndef IERU_CONSTS_VH
`define IERU_CONSTS_VH

// ----------------------------------------
// source counts and address width
// ----------------------------------------
`define IERU_NUM_PERIPH      33
`define IERU_NUM_EXT         6
`define IERU_NUM_NMI         4
`define IERU_ADDR_W          12

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IERU_OFF_IRQ_EN0     12'h000
`define IERU_OFF_IRQ_EN1     12'h004
`define IERU_OFF_DTC_SEL0    12'h008
`define IERU_OFF_DTC_SEL1    12'h00C
`define IERU_OFF_SBY_END0    12'h010
`define IERU_OFF_SBY_END1    12'h014
`define IERU_OFF_EXT_MODE    12'h018
`define IERU_OFF_NMI_CFG     12'h01C
`define IERU_OFF_NMI_EN      12'h020
`define IERU_OFF_STATUS      12'h024
`define IERU_OFF_MASK        12'h028
`define IERU_OFF_SRC0        12'h02C
`define IERU_OFF_SRC1        12'h030

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define IERU_ST_NMI_LSB      8
`define IERU_NMI_PIN         0
`define IERU_NMI_WDT         1
`define IERU_NMI_LVD1        2
`define IERU_NMI_PARITY      3
`define IERU_NMI_CFG_RISE    0
`define IERU_MODE_FALL       2'h0
`define IERU_MODE_RISE       2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define IERU_RST_WORD        32'h0000_0000
`define IERU_RST_EXT_MODE    12'h000
`define IERU_RST_NMI_EN      4'h0

`endif

// ---- src/ieru_sync.v ----
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser, first stage read only by the second
module ieru_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;

endmodule

`default_nettype wire

// ---- src/ieru_edge_det.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ieru_consts.vh"

// per-bit edge detector; mode 0 fall, 1 rise, 2/3 both
module ieru_edge_det #(
   parameter W = 1
) (
   input  wire           clk_i,
   input  wire           rst_n_i,
   input  wire [W-1:0]   lvl_i,
   input  wire [2*W-1:0] mode_i,
   output reg  [W-1:0]   edge_o
);

   reg [W-1:0] prev_r;
   reg         armed_r;
   integer     i;

   // first cycle after reset only loads history, so a pin
   // that is already high does not look like a rising edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_r  <= {W{1'b0}};
         armed_r <= 1'b0;
      end else begin
         prev_r  <= lvl_i;
         armed_r <= 1'b1;
      end
   end

   always @* begin
      edge_o = {W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
         case (mode_i[2*i +: 2])
            `IERU_MODE_FALL: edge_o[i] = armed_r & prev_r[i] & ~lvl_i[i];
            `IERU_MODE_RISE: edge_o[i] = armed_r & ~prev_r[i] & lvl_i[i];
            default:         edge_o[i] = armed_r & (prev_r[i] ^ lvl_i[i]);
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- dv/ieru_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ieru_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        ack_en_i,
   input  wire logic [38:0] nvc_irq_i,
   output var  logic [5:0]  ack_o
);
   initial ack_o = 6'h00;
   // service ack
   // one-cycle ack, then a gap so a cleared line can settle
   always @(posedge clk_i) begin
      ack_o <= (ack_en_i && ack_o == 6'h00) ? nvc_irq_i[38:33] : 6'h00;
   end
endmodule
`default_nettype wire

// ---- dv/ieru_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module ieru_sva #(
   parameter NPER = 33,
   parameter NEXT = 6,
   parameter AW   = 12
) (
   input wire logic                 ref_clk_i,
   input wire logic                 rst_n_i,
   input wire logic                 psel_i,
   input wire logic                 penable_i,
   input wire logic [AW-1:0]        paddr_i,
   input wire logic                 pready_o,
   input wire logic                 pslverr_o,
   input wire logic [NPER-1:0]      periph_irq_i,
   input wire logic                 sleep_mode_i,
   input wire logic                 standby_mode_i,
   input wire logic                 snooze_mode_i,
   input wire logic [NPER+NEXT-1:0] nvc_irq_o,
   input wire logic [NPER+NEXT-1:0] dtc_req_o,
   input wire logic                 nmi_o,
   input wire logic                 wake_o
);
   logic rst_q1;
   logic rst_ok;
   // ----------
   // mirror of the internal reset release
   // ----------
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q1 <= 1'b0;
         rst_ok <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_ok <= rst_q1;
      end
   end
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_ok);
   zero_wait_a: assert property (pready_o)
      else $error("pready low");
   mapped_ok_a: assert property (psel_i && penable_i && paddr_i <= 12'h030 &&
      paddr_i[1:0] == 2'b00 |-> !pslverr_o) else $error("error on mapped access");
   unmapped_err_a: assert property (psel_i && penable_i && paddr_i > 12'h030 |-> pslverr_o)
      else $error("no error on unmapped access");
   periph_cause_a: assert property (
      ((nvc_irq_o[NPER-1:0] | dtc_req_o[NPER-1:0]) & ~$past(periph_irq_i)) == '0)
      else $error("request without source");
   lines_disjoint_a: assert property ((nvc_irq_o & dtc_req_o) == '0)
      else $error("line on both outputs");
   sleep_wake_a: assert property (sleep_mode_i && periph_irq_i != '0 |=> wake_o)
      else $error("sleep not ended");
   nmi_wake_a: assert property ($past(nmi_o) && nmi_o |-> wake_o)
      else $error("nmi without wake");
   no_wake_a: assert property (!$past(nmi_o) && !nmi_o && !$past(sleep_mode_i) &&
      !$past(standby_mode_i) && !$past(snooze_mode_i) |-> !wake_o) else $error("stray wake");
   wake_c: cover property (wake_o);
   nmi_c: cover property (nmi_o);
   dtc_c: cover property (dtc_req_o != '0);
endmodule
bind ieru_top ieru_sva #(.NPER(NPER), .NEXT(NEXT), .AW(AW)) i_sva (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .periph_irq_i(periph_irq_i), .sleep_mode_i(sleep_mode_i),
   .standby_mode_i(standby_mode_i), .snooze_mode_i(snooze_mode_i),
   .nvc_irq_o(nvc_irq_o), .dtc_req_o(dtc_req_o), .nmi_o(nmi_o), .wake_o(wake_o)
);
`default_nettype wire

// ---- dv/tb_interrupt_event_routing_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ieru_consts.vh"
module tb_interrupt_event_routing_unit;
   logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        sleep = 1'b0, stby = 1'b0, snz = 1'b0, ack_en = 1'b0;
   logic        pready, pslverr, nmi, wake, irq, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic [32:0] periph = 33'h0_0000_0000;
   logic [5:0]  pins = 6'h00, ack;
   logic [4:0]  nsrc = 5'h00;
   logic [38:0] nvc, data_transfer_ctrl;
   int          err_total = 0, samples_checked = 0;

   always #5 ref_clk = ~ref_clk;

   ieru_top i_dut (
      .ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .periph_irq_i(periph), .ext_irq_pin_i(pins),
      .ext_irq_ack_i(ack), .nmi_pin_i(nsrc[0]), .wdt_underflow_i(nsrc[1]),
      .wdt_refresh_err_i(nsrc[2]), .voltage_monitor_one_i(nsrc[3]),
      .sram_parity_err_irq_i(nsrc[4]), .sleep_mode_i(sleep), .standby_mode_i(stby),
      .snooze_mode_i(snz), .nvc_irq_o(nvc), .dtc_req_o(data_transfer_ctrl), .nmi_o(nmi), .wake_o(wake),
      .irq_o(irq)
   );
   ieru_cpu_model i_cpu (.clk_i(ref_clk), .ack_en_i(ack_en), .nvc_irq_i(nvc), .ack_o(ack));

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [38:0] got, input logic [38:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_total++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk({7'h00, rdat}, {7'h00, exp});
   endtask

   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(3);
      rd(`IERU_OFF_NMI_EN, 32'h0000_0000);
      rd(12'h100, 32'h0000_0000);
      chk({38'h0, rerr}, 39'h1);
      // ----------
      // peripheral lines, transfer split, wake
      // ----------
      wr(`IERU_OFF_IRQ_EN0, 32'hFFFF_FFFF);
      wr(`IERU_OFF_IRQ_EN1, 32'h0000_007F);
      wr(`IERU_OFF_DTC_SEL1, 32'h0000_0001);
      periph <= 33'h1_0000_0020;
      cyc(3);
      chk(nvc, 39'h00_0000_0020);
      chk(data_transfer_ctrl, 39'h01_0000_0000);
      rd(`IERU_OFF_SRC1, 32'h0000_0001);
      stby <= 1'b1;
      cyc(3);
      chk({38'h0, wake}, 39'h0);
      wr(`IERU_OFF_SBY_END0, 32'h0000_0020);
      cyc(3);
      chk({38'h0, wake}, 39'h1);
      stby <= 1'b0;
      snz <= 1'b1;
      cyc(3);
      chk({38'h0, wake}, 39'h1);
      wr(`IERU_OFF_SBY_END0, 32'h0000_0000);
      cyc(3);
      chk({38'h0, wake}, 39'h0);
      snz <= 1'b0;
      sleep <= 1'b1;
      cyc(3);
      chk({38'h0, wake}, 39'h1);
      sleep <= 1'b0;
      periph <= 33'h0_0000_0000;
      // ----------
      // pin edges in modes 0 to 2, mask and clear
      // ----------
      for (int m = 0; m < 3; m++) begin
         wr(`IERU_OFF_EXT_MODE, {20'h0_0000, {6{m[1:0]}}});
         wr(`IERU_OFF_MASK, 32'h0000_003F);
         pins <= 6'h3F;
         cyc(8);
         rd(`IERU_OFF_STATUS, (m == 0) ? 32'h0000_0000 : 32'h0000_003F);
         chk({38'h0, irq}, (m == 0) ? 39'h0 : 39'h1);
         wr(`IERU_OFF_MASK, 32'h0000_0000);
         cyc(2);
         chk({38'h0, irq}, 39'h0);
         wr(`IERU_OFF_STATUS, 32'h0000_003F);
         pins <= 6'h00;
         cyc(8);
         rd(`IERU_OFF_STATUS, (m == 1) ? 32'h0000_0000 : 32'h0000_003F);
         wr(`IERU_OFF_STATUS, 32'h0000_003F);
      end
      ack_en <= 1'b1;
      pins <= 6'h3F;
      cyc(12);
      rd(`IERU_OFF_STATUS, 32'h0000_0000);
      // ----------
      // watchdog as maskable source, enables left at reset
      // ----------
      wr(`IERU_OFF_MASK, 32'h0000_0200);
      nsrc <= 5'h02;
      cyc(2);
      nsrc <= 5'h00;
      cyc(3);
      chk({38'h0, irq}, 39'h1);
      chk({38'h0, nmi}, 39'h0);
      rd(`IERU_OFF_STATUS, 32'h0000_0200);
      wr(`IERU_OFF_STATUS, 32'h0000_0F00);
      wr(`IERU_OFF_MASK, 32'h0000_0000);
      // ----------
      // nonmaskable sources, enables locked
      // ----------
      wr(`IERU_OFF_NMI_CFG, 32'h0000_0001);
      wr(`IERU_OFF_NMI_EN, 32'h0000_000F);
      wr(`IERU_OFF_NMI_EN, 32'h0000_0000);
      rd(`IERU_OFF_NMI_EN, 32'h0000_000F);
      stby <= 1'b1;
      // pin rise select taken as set, event reaches us
      for (int k = 0; k < 5; k++) begin
         nsrc <= 5'h01 << k;
         cyc(8);
         nsrc <= 5'h00;
         cyc(4);
         chk({38'h0, nmi}, 39'h1);
         chk({38'h0, wake}, 39'h1);
         rd(`IERU_OFF_STATUS, 32'h1 << (k == 0 ? 8 : k < 3 ? 9 : k + 7));
         wr(`IERU_OFF_STATUS, 32'h0000_0F00);
         cyc(3);
         chk({38'h0, nmi}, 39'h0);
      end
      // ----------
      // second reset unlocks the nonmaskable enables
      // ----------
      stby <= 1'b0;
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      cyc(3);
      rd(`IERU_OFF_NMI_EN, 32'h0000_0000);
      chk({38'h0, wake}, 39'h0);
      wr(`IERU_OFF_NMI_EN, 32'h0000_0003);
      rd(`IERU_OFF_NMI_EN, 32'h0000_0003);
      give_verdict();
   end
endmodule
`default_nettype wire
